//--- pseudo_channel_ctrl_front_end.sv
// Front end of one stacked DRAM memory channel: two pseudo channel AXI4
// slave ports, thermal throttling, reorder tracking and response queues.
// Assumes single-beat AXI bursts and a memory side with valid/ready pairs.
//
// Function
// - With backpressure, soft FIFOs hold read data and write responses.
// - Throttle AXI traffic when temperature exceeds one shared threshold.
// - Throttling acts only when this controller's throttle enable is set.
// - Throttle ratio is a percentage; 0 none, 100 full.
// - With reorder enabled, read data returns in read issue order.
// - Without reorder, data may return out of order; master sorts by ID.
// - Same-ID transactions go to memory in arrival order.
// - 32-byte mode splits addresses by three orders; column bit 6 zero.
// - 64-byte mode uses three orders; column bits 1..0 forced zero.
// - Stack select exists only for an eight-high stack.
// - A channel is 128 bits from two 64-bit pseudo channels, own ports.
// - A controller exists only on selected channels 0 to 7.
// - While throttling, awready, wready and arready are low.
// - Catastrophic trip stops all memory commands and stalls for good.
// - 64-byte access uses burst length 8, 32-byte uses burst length 4.
`timescale 1ns/1ps
module pseudo_channel_ctrl_front_end
  import pc_front_pkg::*;
#(
  parameter int          CHANNEL_ID   = 0,
  parameter bit          CTRL_PRESENT = 1'b1,
  parameter bit          BACKPRESSURE = 1'b1,
  parameter bit          REORDER      = 1'b1,
  parameter addr_order_t ADDR_ORDER   = ORD_SID_BG_BANK_ROW_COL,
  parameter bit          ACCESS_64B   = 1'b1,
  parameter bit          STACK_8H     = 1'b1,
  parameter int          FIFO_DEPTH   = 4,
  parameter int          ROB_DEPTH    = 8
)
(
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic [7:0]            i_temp_c,
  input  wire logic                  i_cattrip,
  input  wire logic [NUM_PC-1:0]     i_ar_valid,
  input  wire axi_req_t              i_ar [NUM_PC],
  output logic      [NUM_PC-1:0]     o_ar_ready,
  input  wire logic [NUM_PC-1:0]     i_aw_valid,
  input  wire axi_req_t              i_aw [NUM_PC],
  output logic      [NUM_PC-1:0]     o_aw_ready,
  input  wire logic [NUM_PC-1:0]     i_w_valid,
  input  wire logic [DATA_W-1:0]     i_w_data [NUM_PC],
  output logic      [NUM_PC-1:0]     o_w_ready,
  output logic      [NUM_PC-1:0]     o_r_valid,
  output axi_rdata_t                 o_r [NUM_PC],
  input  wire logic [NUM_PC-1:0]     i_r_ready,
  output logic      [NUM_PC-1:0]     o_b_valid,
  output logic      [ID_W-1:0]       o_b_id [NUM_PC],
  input  wire logic [NUM_PC-1:0]     i_b_ready,
  output logic      [NUM_PC-1:0]     o_mem_cmd_valid,
  output mem_cmd_t                   o_mem_cmd [NUM_PC],
  output logic      [DATA_W-1:0]     o_mem_wdata [NUM_PC],
  input  wire logic [NUM_PC-1:0]     i_mem_cmd_ready,
  input  wire logic [NUM_PC-1:0]     i_mem_rd_valid,
  input  wire axi_rdata_t            i_mem_rd [NUM_PC],
  output logic      [NUM_PC-1:0]     o_mem_rd_ready,
  output logic      [ID_W-1:0]       o_mem_rd_next_id [NUM_PC],
  input  wire logic [NUM_PC-1:0]     i_mem_wr_done_valid,
  input  wire logic [ID_W-1:0]       i_mem_wr_done_id [NUM_PC],
  output logic      [NUM_PC-1:0]     o_mem_wr_done_ready
);
  localparam int FD   = BACKPRESSURE ? FIFO_DEPTH : 2;
  localparam int PW   = $clog2(FD);
  localparam int CW   = $clog2(FD + 1);
  localparam int RW   = $bits(axi_rdata_t);
  localparam int RPW  = $clog2(ROB_DEPTH);
  localparam int RCW  = $clog2(ROB_DEPTH + 1);
  localparam int BURST_LEN = ACCESS_64B ? BL_64B : BL_32B;
  localparam bit ACTIVE = CTRL_PRESENT && CHANNEL_ID <= MAX_CHANNEL;

  logic             thr_en, next_thr_en;
  logic [7:0]       thresh, next_thresh;
  logic [6:0]       rate, next_rate;
  logic [6:0]       pct_cnt, next_pct_cnt;
  logic             cat_stall, next_cat_stall;
  logic             throttling, next_throttling;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr;
  logic             apb_wr;

  assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;

  // Throttling blanks readies for the first rate-percent of every 100 cycles.
  always_comb
  begin
    next_thr_en = thr_en;
    next_thresh = thresh;
    next_rate = rate;
    next_pready = i_psel & ~i_penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    if (apb_wr && i_paddr == APB_CTRL)
      next_thr_en = i_pwdata[CTRL_THR_EN];
    if (apb_wr && i_paddr == APB_THRESH)
      next_thresh = i_pwdata[7:0];
    if (apb_wr && i_paddr == APB_RATE)
      next_rate = (i_pwdata > 32'(PCT_FULL)) ? PCT_FULL : i_pwdata[6:0];
    if (i_psel && !i_penable)
    begin
      case (i_paddr)
        APB_CTRL:   next_prdata[CTRL_THR_EN] = thr_en;
        APB_THRESH: next_prdata[7:0] = thresh;
        APB_RATE:   next_prdata[6:0] = rate;
        APB_STATUS:
        begin
          next_prdata[7:0] = i_temp_c;
          next_prdata[STAT_THR] = throttling;
          next_prdata[STAT_CAT] = cat_stall;
          next_prdata[STAT_CH_LSB +: 3] = 3'(CHANNEL_ID);
        end
        default:    next_pslverr = 1'b1;
      endcase
    end
    next_pct_cnt = (pct_cnt == PCT_LAST) ? 7'h0 : pct_cnt + 7'h1;
    next_cat_stall = cat_stall | i_cattrip;
    next_throttling = next_thr_en && (i_temp_c > next_thresh) &&
                      (next_pct_cnt < next_rate);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      thr_en <= 1'b0;
      thresh <= THRESH_RST;
      rate <= RATE_RST;
      pct_cnt <= 7'h0;
      cat_stall <= 1'b0;
      throttling <= 1'b0;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      thr_en <= next_thr_en;
      thresh <= next_thresh;
      rate <= next_rate;
      pct_cnt <= next_pct_cnt;
      cat_stall <= next_cat_stall;
      throttling <= next_throttling;
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // Queues 2p hold read data and 2p+1 write responses of pseudo channel p.
  logic [RW-1:0] q_mem  [2*NUM_PC][FD];
  logic [PW-1:0] q_wp   [2*NUM_PC];
  logic [PW-1:0] q_rp   [2*NUM_PC];
  logic [CW-1:0] q_cnt  [2*NUM_PC];
  logic          q_push [2*NUM_PC];
  logic          q_pop  [2*NUM_PC];
  logic          q_val  [2*NUM_PC];
  logic          q_rdy  [2*NUM_PC];
  logic [RW-1:0] q_in   [2*NUM_PC];

  for (genvar q = 0; q < 2 * NUM_PC; q++)
  begin : g_q
    logic [CW-1:0] next_cnt;
    logic          next_val, next_rdy;
    always_comb
    begin
      next_cnt = q_cnt[q] + CW'(q_push[q]) - CW'(q_pop[q]);
      next_val = next_cnt != '0;
      next_rdy = next_cnt < CW'(FD);
    end
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        q_wp[q] <= '0;
        q_rp[q] <= '0;
        q_cnt[q] <= '0;
        q_val[q] <= 1'b0;
        q_rdy[q] <= 1'b0;
      end
      else
      begin
        if (q_push[q])
        begin
          q_mem[q][q_wp[q]] <= q_in[q];
          q_wp[q] <= (q_wp[q] == PW'(FD - 1)) ? '0 : q_wp[q] + PW'(1);
        end
        if (q_pop[q])
          q_rp[q] <= (q_rp[q] == PW'(FD - 1)) ? '0 : q_rp[q] + PW'(1);
        q_cnt[q] <= next_cnt;
        q_val[q] <= next_val;
        q_rdy[q] <= next_rdy && ACTIVE;
      end
    end
    a_q_no_overflow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      q_push[q] && !q_pop[q] |-> q_cnt[q] < CW'(FD))
      else $error("response queue overflow");
  end

  for (genvar p = 0; p < NUM_PC; p++)
  begin : g_pc
    logic                 full, next_full, prio_wr, next_prio_wr;
    logic                 next_ar_rdy, next_aw_rdy, next_cmd_v;
    logic                 ar_fire, aw_fire, rd_take, cmd_fire, stall;
    mem_cmd_t             next_cmd;
    logic [DATA_W-1:0]    next_wdata;
    logic [ID_W-1:0]      rob_mem [ROB_DEPTH];
    logic [RPW-1:0]       rob_wp, rob_rp, next_rob_rp;
    logic [RCW-1:0]       rob_cnt, next_rob_cnt;
    logic [ID_W-1:0]      next_head;

    assign ar_fire  = i_ar_valid[p] & o_ar_ready[p];
    assign aw_fire  = i_aw_valid[p] & o_aw_ready[p] & i_w_valid[p];
    assign cmd_fire = o_mem_cmd_valid[p] & i_mem_cmd_ready[p];
    assign rd_take  = i_mem_rd_valid[p] & o_mem_rd_ready[p];
    assign stall    = next_cat_stall | next_throttling;
    assign q_push[2*p]   = rd_take;
    assign q_in[2*p]     = i_mem_rd[p];
    assign q_pop[2*p]    = q_val[2*p] & i_r_ready[p];
    assign q_push[2*p+1] = i_mem_wr_done_valid[p] & o_mem_wr_done_ready[p];
    assign q_in[2*p+1]   = {i_mem_wr_done_id[p], {DATA_W{1'b0}}};
    assign q_pop[2*p+1]  = q_val[2*p+1] & i_b_ready[p];
    assign o_r_valid[p]  = q_val[2*p];
    assign o_r[p]        = q_mem[2*p][q_rp[2*p]];
    assign o_b_valid[p]  = q_val[2*p+1];
    assign o_b_id[p]     = q_mem[2*p+1][q_rp[2*p+1]][RW-1 -: ID_W];
    assign o_mem_rd_ready[p]      = q_rdy[2*p];
    assign o_mem_wr_done_ready[p] = q_rdy[2*p+1];

    // A single command slot per port keeps same-ID traffic in order.
    always_comb
    begin
      next_full = (full & ~cmd_fire) | ar_fire | aw_fire;
      next_cmd = o_mem_cmd[p];
      next_wdata = o_mem_wdata[p];
      next_prio_wr = prio_wr;
      if (aw_fire)
      begin
        next_cmd = map_addr(i_aw[p].addr, ADDR_ORDER, ACCESS_64B,
                            STACK_8H);
        next_cmd.write = 1'b1;
        next_cmd.id = i_aw[p].id;
        next_wdata = i_w_data[p];
        next_prio_wr = 1'b0;
      end
      if (ar_fire)
      begin
        next_cmd = map_addr(i_ar[p].addr, ADDR_ORDER, ACCESS_64B,
                            STACK_8H);
        next_cmd.id = i_ar[p].id;
        next_prio_wr = 1'b1;
      end
      next_cmd_v = next_full & ~next_cat_stall;
      // Readies are granted one cycle ahead, to only one of read or write at a time.
      next_aw_rdy = ACTIVE && !next_full && !stall &&
                    i_aw_valid[p] && i_w_valid[p] &&
                    (next_prio_wr || !i_ar_valid[p]);
      next_ar_rdy = ACTIVE && !next_full && !stall && i_ar_valid[p] &&
                    !next_aw_rdy && !(REORDER && next_rob_cnt ==
                    RCW'(ROB_DEPTH));
    end

    // Reorder tracking: memory must return the ID on o_mem_rd_next_id.
    always_comb
    begin
      next_rob_cnt = rob_cnt + RCW'(ar_fire) - RCW'(rd_take);
      next_rob_rp = rd_take ?
        ((rob_rp == RPW'(ROB_DEPTH - 1)) ? '0 : rob_rp + RPW'(1)) : rob_rp;
      if (rob_cnt == '0 || (rob_cnt == RCW'(1) && rd_take))
        next_head = ar_fire ? i_ar[p].id : '0;
      else
        next_head = rob_mem[next_rob_rp];
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        full <= 1'b0;
        prio_wr <= 1'b0;
        o_mem_cmd_valid[p] <= 1'b0;
        o_mem_cmd[p] <= '0;
        o_mem_wdata[p] <= '0;
        o_ar_ready[p] <= 1'b0;
        o_aw_ready[p] <= 1'b0;
        o_w_ready[p] <= 1'b0;
        rob_wp <= '0;
        rob_rp <= '0;
        rob_cnt <= '0;
        o_mem_rd_next_id[p] <= '0;
      end
      else
      begin
        full <= next_full;
        prio_wr <= next_prio_wr;
        o_mem_cmd_valid[p] <= next_cmd_v;
        o_mem_cmd[p] <= next_cmd;
        o_mem_wdata[p] <= next_wdata;
        o_ar_ready[p] <= next_ar_rdy;
        o_aw_ready[p] <= next_aw_rdy;
        o_w_ready[p] <= next_aw_rdy;
        if (ar_fire && REORDER)
        begin
          rob_mem[rob_wp] <= i_ar[p].id;
          rob_wp <= (rob_wp == RPW'(ROB_DEPTH - 1)) ? '0 : rob_wp + RPW'(1);
        end
        if (REORDER)
        begin
          rob_rp <= next_rob_rp;
          rob_cnt <= next_rob_cnt;
          o_mem_rd_next_id[p] <= next_head;
        end
      end
    end

    a_cat_stall_all: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      $rose(cat_stall) |-> ##1 (!o_mem_cmd_valid[p] && !o_ar_ready[p] &&
      !o_aw_ready[p]) [*8])
      else $error("traffic continues after catastrophic trip");
    a_throttle_ready: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      throttling |-> !o_ar_ready[p] && !o_aw_ready[p] && !o_w_ready[p])
      else $error("ready high while throttling");
    a_full_ratio: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      thr_en && rate == PCT_FULL && $past(i_temp_c) > thresh |->
      throttling)
      else $error("full ratio did not throttle");
    a_one_grant: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !(o_ar_ready[p] && o_aw_ready[p]))
      else $error("read and write granted together");
    a_col_fixed: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_mem_cmd_valid[p] |-> !o_mem_cmd[p].col[6] && !o_mem_cmd[p].col[0] &&
      (!ACCESS_64B || !o_mem_cmd[p].col[1]))
      else $error("forced column bits not zero");
    a_sid_absent: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_mem_cmd_valid[p] && !STACK_8H |-> !o_mem_cmd[p].stack_select_field)
      else $error("stack select used on four-high stack");
    a_burst_mode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_mem_cmd_valid[p] |-> o_mem_cmd[p].paired_burst_mode ==
      (BURST_LEN == BL_64B))
      else $error("burst mode differs from access size");
    a_rob_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      REORDER && rd_take |-> i_mem_rd[p].id == o_mem_rd_next_id[p])
      else $error("read data out of issue order");
    a_cmd_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_mem_cmd_valid[p] && !i_mem_cmd_ready[p] && !i_cattrip |=>
      o_mem_cmd_valid[p] && $stable(o_mem_cmd[p]))
      else $error("pending command changed before issue");
  end
  a_absent_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !ACTIVE |-> o_ar_ready == '0 && o_aw_ready == '0)
    else $error("absent controller accepted a request");
endmodule

//--- pc_front_pkg.sv
// Types, register map and address mapping for the pseudo channel front end.
// Assumes one core clock; the memory side answers with valid/ready pairs.
package pc_front_pkg;
  localparam int ID_W        = 4;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 256;
  localparam int NUM_PC      = 2;
  localparam int PC_DQ_W     = 64;
  localparam int CH_DQ_W     = 128;
  localparam int ROW_W       = 14;
  localparam int COL_W       = 7;
  localparam int OFS_W       = 5;
  localparam int BL_32B      = 4;
  localparam int BL_64B      = 8;
  localparam int MAX_CHANNEL = 7;
  localparam logic [6:0] PCT_FULL   = 7'h64;
  localparam logic [6:0] PCT_LAST   = 7'h63;
  localparam logic [7:0] APB_CTRL   = 8'h00;
  localparam logic [7:0] APB_THRESH = 8'h04;
  localparam logic [7:0] APB_RATE   = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam logic [7:0] THRESH_RST = 8'h55;
  localparam logic [6:0] RATE_RST   = 7'h32;
  localparam int CTRL_THR_EN = 0;
  localparam int STAT_THR    = 8;
  localparam int STAT_CAT    = 9;
  localparam int STAT_CH_LSB = 12;

  typedef enum logic [2:0]
  {
    ORD_SID_BG_BANK_ROW_COL = 3'h1,
    ORD_SID_ROW_BANK_COL_BG = 3'h2,
    ORD_ROW_SID_BANK_COL_BG = 3'h4
  } addr_order_t;

  typedef struct packed
  {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
  } axi_req_t;

  typedef struct packed
  {
    logic [ID_W-1:0]   id;
    logic [DATA_W-1:0] data;
  } axi_rdata_t;

  typedef struct packed
  {
    logic             write;
    logic [ID_W-1:0]  id;
    logic             stack_select_field;
    logic [1:0]       bank_group_field;
    logic [1:0]       bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic             paired_burst_mode;
  } mem_cmd_t;

  // Fields are listed from the top address bit down to the lowest one.
  function automatic mem_cmd_t map_addr(input logic [ADDR_W-1:0] addr,
                                        input addr_order_t ord,
                                        input logic size64,
                                        input logic stack8);
    mem_cmd_t                m;
    logic [ADDR_W-OFS_W-1:0] a;
    logic [4:0]              c;
    m = '0;
    a = addr[ADDR_W-1:OFS_W];
    m.paired_burst_mode = size64;
    if (ord == ORD_SID_BG_BANK_ROW_COL)
    begin
      c = a[4:0];
      m.row = a[18:5];
      m.bank = a[20:19];
      m.bank_group_field = a[22:21];
      m.stack_select_field = stack8 & a[23];
    end
    else
    begin
      c = size64 ? {a[6:3], a[0]} : a[6:2];
      m.bank_group_field = size64 ? a[2:1] : a[1:0];
      m.bank = a[8:7];
      if (ord == ORD_ROW_SID_BANK_COL_BG && stack8)
      begin
        m.stack_select_field = a[9];
        m.row = a[23:10];
      end
      else
      begin
        m.stack_select_field = stack8 & a[23];
        m.row = a[22:9];
      end
    end
    m.col = {1'b0, c[4:1], c[0] & ~size64, 1'b0};
    return m;
  endfunction
endpackage

//--- mem_side_model.sv
// Memory side stand-in for the pseudo channel front end: takes commands,
// returns read data and write completions in command order per port.
// Assumes the front end keeps the commands of each port in issue order.
`timescale 1ns/1ps
module mem_side_model
  import pc_front_pkg::*;
#(
  parameter int STALL = 3
)
(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic [NUM_PC-1:0] i_cmd_valid,
  input  wire mem_cmd_t          i_cmd [NUM_PC],
  output logic      [NUM_PC-1:0] o_cmd_ready,
  output logic      [NUM_PC-1:0] o_rd_valid,
  output axi_rdata_t             o_rd [NUM_PC],
  input  wire logic [NUM_PC-1:0] i_rd_ready,
  output logic      [NUM_PC-1:0] o_wd_valid,
  output logic      [ID_W-1:0]   o_wd_id [NUM_PC],
  input  wire logic [NUM_PC-1:0] i_wd_ready
);
  axi_rdata_t      rq [NUM_PC][$];
  logic [ID_W-1:0] wq [NUM_PC][$];
  int              cnt;

  // Idle data is inverted every cycle so a stale beat can never match.
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt = 0;
      o_cmd_ready <= '0;
      o_rd_valid <= '0;
      o_wd_valid <= '0;
      for (int p = 0; p < NUM_PC; p++)
      begin
        rq[p].delete();
        wq[p].delete();
        o_rd[p] <= '0;
        o_wd_id[p] <= '0;
      end
    end
    else
    begin
      cnt++;
      for (int p = 0; p < NUM_PC; p++)
      begin
        if (o_rd_valid[p] && i_rd_ready[p])
          void'(rq[p].pop_front());
        if (o_wd_valid[p] && i_wd_ready[p])
          void'(wq[p].pop_front());
        if (i_cmd_valid[p] && o_cmd_ready[p] && i_cmd[p].write)
          wq[p].push_back(i_cmd[p].id);
        else if (i_cmd_valid[p] && o_cmd_ready[p])
          rq[p].push_back({i_cmd[p].id,
                           {8{32'({i_cmd[p].row, i_cmd[p].col})}}});
        o_cmd_ready[p] <= (cnt % STALL) != p;
        o_rd_valid[p] <= rq[p].size() != 0;
        o_rd[p] <= (rq[p].size() != 0) ? rq[p][0] : ~o_rd[p];
        o_wd_valid[p] <= wq[p].size() != 0;
        o_wd_id[p] <= (wq[p].size() != 0) ? wq[p][0] : ~o_wd_id[p];
      end
    end
  end
endmodule

//--- pseudo_channel_ctrl_front_end_tb.sv
// Self-checking bench for the pseudo channel front end: APB registers,
// AXI traffic on both ports, throttling and the catastrophic trip.
// Assumes the memory side stand-in answers every command in order.
`timescale 1ns/1ps
module pseudo_channel_ctrl_front_end_tb;
  import pc_front_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_arst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [7:0]        temp_c = 8'h3c;
  logic              cattrip = 1'b0;
  logic [1:0]        ar_valid = '0;
  logic [1:0]        aw_valid = '0;
  logic [1:0]        w_valid = '0;
  logic [1:0]        r_ready = '1;
  logic [1:0]        b_ready = '1;
  logic [1:0]        ar_ready, aw_ready, w_ready, r_valid, b_valid;
  logic [1:0]        cmd_valid, cmd_ready, rd_valid, rd_ready;
  logic [1:0]        wd_valid, wd_ready;
  axi_req_t          ar [NUM_PC];
  axi_req_t          aw [NUM_PC];
  logic [DATA_W-1:0] w_data [NUM_PC];
  logic [DATA_W-1:0] mem_wdata [NUM_PC];
  axi_rdata_t        r [NUM_PC];
  axi_rdata_t        rd [NUM_PC];
  logic [ID_W-1:0]   b_id [NUM_PC];
  logic [ID_W-1:0]   wd_id [NUM_PC];
  mem_cmd_t          cmd [NUM_PC];
  mem_cmd_t          exp_m;
  mem_cmd_t          cq [NUM_PC][$];
  axi_rdata_t        rq [NUM_PC][$];
  logic [ID_W-1:0]   bq [NUM_PC][$];
  logic [DATA_W-1:0] dq [NUM_PC][$];
  int                error_cnt = 0;
  int                n_compared = 0;
  logic [31:0]       seed = 32'h0001282a;
  logic [31:0]       rnd;
  bit                stall = 1'b0;

  always #12.5 i_clk = ~i_clk;

  pseudo_channel_ctrl_front_end #(.CHANNEL_ID(3), .BACKPRESSURE(1'b1),
    .REORDER(1'b1)) dut_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_temp_c(temp_c), .i_cattrip(cattrip),
    .i_ar_valid(ar_valid), .i_ar(ar), .o_ar_ready(ar_ready),
    .i_aw_valid(aw_valid), .i_aw(aw), .o_aw_ready(aw_ready),
    .i_w_valid(w_valid), .i_w_data(w_data), .o_w_ready(w_ready),
    .o_r_valid(r_valid), .o_r(r), .i_r_ready(r_ready),
    .o_b_valid(b_valid), .o_b_id(b_id), .i_b_ready(b_ready),
    .o_mem_cmd_valid(cmd_valid), .o_mem_cmd(cmd),
    .o_mem_wdata(mem_wdata), .i_mem_cmd_ready(cmd_ready),
    .i_mem_rd_valid(rd_valid), .i_mem_rd(rd), .o_mem_rd_ready(rd_ready),
    .o_mem_rd_next_id(), .i_mem_wr_done_valid(wd_valid),
    .i_mem_wr_done_id(wd_id), .o_mem_wr_done_ready(wd_ready));

  mem_side_model mem_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid),
    .o_rd(rd), .i_rd_ready(rd_ready), .o_wd_valid(wd_valid),
    .o_wd_id(wd_id), .i_wd_ready(wd_ready));

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Fixed mapping: stack, bank group, bank, row, column; 64-byte, 8-high.
  function automatic mem_cmd_t exp_map(input logic wr,
    input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] ad);
    mem_cmd_t m;
    m = '0;
    m.write = wr;
    m.id = id;
    m.stack_select_field = ad[28];
    m.bank_group_field = ad[27:26];
    m.bank = ad[25:24];
    m.row = ad[23:10];
    m.col = {1'b0, ad[9:6], 2'b00};
    m.paired_burst_mode = 1'b1;
    return m;
  endfunction

  task automatic check(input string nm, input logic [259:0] seen,
                       input logic [259:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] exp, input logic err);
    int k;
    k = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      complete_run();
    end
    check("pslverr", pslverr, err);
    if (!wr)
      check("prdata", prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic axi_req(input int p, input logic wr,
    input logic [ID_W-1:0] id, input int lim, input bit exp_ok);
    int k;
    bit ok;
    logic [31:0] a;
    a = next_rand();
    k = 0;
    ok = 1'b0;
    @(posedge i_clk);
    if (wr)
    begin
      aw[p] <= '{id, a};
      w_data[p] <= {8{a}};
      aw_valid[p] <= 1'b1;
      w_valid[p] <= 1'b1;
    end
    else
    begin
      ar[p] <= '{id, a};
      ar_valid[p] <= 1'b1;
    end
    while (!ok && k < lim)
    begin
      @(posedge i_clk);
      k++;
      ok = wr ? aw_ready[p] : ar_ready[p];
    end
    ar_valid[p] <= 1'b0;
    aw_valid[p] <= 1'b0;
    w_valid[p] <= 1'b0;
    check("accepted", ok, exp_ok);
    if (exp_ok && !ok)
      complete_run();
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (cq[0].size() + cq[1].size() + rq[0].size() + rq[1].size()
           + bq[0].size() + bq[1].size() != 0 && k < 2000)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k == 2000)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  always @(posedge i_clk)
  begin
    rnd = next_rand();
    r_ready <= stall ? rnd[1:0] : 2'h3;
    b_ready <= stall ? rnd[3:2] : 2'h3;
    for (int p = 0; p < NUM_PC; p++)
    begin
      if (ar_valid[p] && ar_ready[p])
      begin
        exp_m = exp_map(1'b0, ar[p].id, ar[p].addr);
        cq[p].push_back(exp_m);
        rq[p].push_back({ar[p].id, {8{32'({exp_m.row, exp_m.col})}}});
      end
      if (aw_valid[p] && aw_ready[p])
      begin
        check("w_ready", w_ready[p], 1'b1);
        cq[p].push_back(exp_map(1'b1, aw[p].id, aw[p].addr));
        bq[p].push_back(aw[p].id);
        dq[p].push_back(w_data[p]);
      end
      if (cmd_valid[p] && cmd_ready[p])
      begin
        check("mem_cmd", cmd[p], cq[p].pop_front());
        if (cmd[p].write)
          check("mem_wdata", mem_wdata[p], dq[p].pop_front());
      end
      if (r_valid[p] && r_ready[p])
        check("r_beat", r[p], rq[p].pop_front());
      if (b_valid[p] && b_ready[p])
        check("b_id", b_id[p], bq[p].pop_front());
    end
  end

  initial
  begin
    #2000000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    for (int p = 0; p < NUM_PC; p++)
    begin
      ar[p] = '0;
      aw[p] = '0;
      w_data[p] = '0;
    end
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(1'b0, APB_CTRL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, APB_THRESH, 32'h0, 32'(THRESH_RST), 1'b0);
    apb(1'b0, APB_RATE, 32'h0, 32'(RATE_RST), 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, APB_RATE, 32'h7f, 32'h0, 1'b0);
    apb(1'b0, APB_RATE, 32'h0, 32'(PCT_FULL), 1'b0);
    apb(1'b0, APB_STATUS, 32'h0, 32'h0000303c, 1'b0);
    $display("Test registers done");
    stall = 1'b1;
    for (int i = 1; i < 4; i++)
      axi_req(0, 1'b0, 4'(i), 64, 1'b1);
    repeat (24)
      axi_req(int'(next_rand() & 1), seed[1], seed[5:2], 64, 1'b1);
    drain();
    $display("Test traffic done");
    apb(1'b1, APB_THRESH, 32'h3b, 32'h0, 1'b0);
    apb(1'b1, APB_CTRL, 32'h1, 32'h0, 1'b0);
    axi_req(0, 1'b0, 4'h1, 150, 1'b0);
    axi_req(1, 1'b1, 4'h2, 150, 1'b0);
    apb(1'b0, APB_STATUS, 32'h0, 32'h0000313c, 1'b0);
    apb(1'b1, APB_CTRL, 32'h0, 32'h0, 1'b0);
    axi_req(0, 1'b1, 4'h3, 64, 1'b1);
    apb(1'b1, APB_CTRL, 32'h1, 32'h0, 1'b0);
    apb(1'b1, APB_RATE, 32'h0, 32'h0, 1'b0);
    axi_req(1, 1'b0, 4'h4, 64, 1'b1);
    apb(1'b1, APB_RATE, 32'h64, 32'h0, 1'b0);
    apb(1'b1, APB_THRESH, 32'h3c, 32'h0, 1'b0);
    axi_req(1, 1'b1, 4'h5, 64, 1'b1);
    drain();
    $display("Test throttling done");
    apb(1'b1, APB_CTRL, 32'h0, 32'h0, 1'b0);
    cattrip <= 1'b1;
    axi_req(0, 1'b0, 4'h6, 50, 1'b0);
    cattrip <= 1'b0;
    axi_req(1, 1'b1, 4'h7, 50, 1'b0);
    apb(1'b0, APB_STATUS, 32'h0, 32'h0000323c, 1'b0);
    $display("Test trip done");
    complete_run();
  end
endmodule
